// *** src/controller_setup_words.sv ***
// Setup word bank with AHB-Lite slave, startup, cycle timing and filter decode
`timescale 1ns/1ns
`default_nettype none
`include "setup_words_defines.svh"

// Overview of operation
// - Designation 02 selects stored startup mode
// - Designation picks panel, resume or stored mode
// - Startup words apply only after restart
// - Hold flags from bits 8-11, 12-15
// - Selector drives pulses on one word only
// - Run-time words latch at operation start
// - Serial share: fixed 5% or BCD percent
// - Service time clamped 0.256 to 65.536 ms
// - Stopped controller services ports 10 ms
// - Tool port share uses same scheme
// - Monitor code picks 120 ms or unit
// - Overrun limit is BCD times unit
// - Minimum cycle time pads scan cycle
// - Filter fields map to input groups
module controller_setup_words
  import setup_words_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // Panel and scan engine
  input  wire logic [1:0]  i_panel_mode,
  input  wire logic        i_scan_done,
  // Operating state
  output logic [1:0]       o_op_mode,
  output logic             o_io_hold_flag,
  output logic             o_forced_status_hold_flag,
  output logic             o_cycle_start,
  // Derived settings
  output logic [15:0]      o_pulse_word_onehot,
  output logic [13:0]      o_serial_service_ticks,
  output logic [13:0]      o_tool_service_ticks,
  output logic [7:0]       o_filter_first_lo_ms,
  output logic [7:0]       o_filter_first_hi_ms,
  output logic [7:0]       o_filter_second_word_ms,
  output logic [15:0]      o_board_port1_service,
  output logic [15:0]      o_board_port2_service,
  // Interrupt
  output logic             o_irq
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic [6:0] bcd2(input logic [7:0] b);
    bcd2 = 7'(b[7:4]) * 7'd10 + 7'(b[3:0]);
  endfunction

  // Percentage of the cycle, clamped to the legal service window
  function automatic logic [13:0] service_ticks(input logic [15:0] w,
                                                input logic [23:0] cyc);
    logic [6:0]  pct;
    logic [30:0] prod;
    logic [30:0] q;
    pct = (w[`CODE_HI] == `SHARE_BCD) ? bcd2(w[`CODE_LO]) : 7'(`SHARE_DEFAULT_PCT);
    prod = 31'(pct) * 31'(cyc);
    q = prod / 31'd100;
    if (q < 31'(`SERVICE_MIN_TICKS))
      service_ticks = 14'(`SERVICE_MIN_TICKS);
    else if (q > 31'(`SERVICE_MAX_TICKS))
      service_ticks = 14'(`SERVICE_MAX_TICKS);
    else
      service_ticks = q[13:0];
  endfunction

  function automatic logic [7:0] filter_ms(input logic [3:0] c);
    case (c)
      4'h1:    filter_ms = 8'h01;
      4'h2:    filter_ms = 8'h02;
      4'h3:    filter_ms = 8'h04;
      4'h4:    filter_ms = 8'h08;
      4'h5:    filter_ms = 8'h10;
      4'h6:    filter_ms = 8'h20;
      4'h7:    filter_ms = 8'h40;
      4'h8:    filter_ms = 8'h80;
      default: filter_ms = 8'(`FILTER_DEFAULT_MS);
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Reset release and input synchronisers
  // ------------------------------------------------------------------
  logic       rst_meta_n;
  logic       rst_n;
  logic [1:0] panel_meta;
  logic [1:0] panel_sync;

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      panel_meta <= 2'h0;
      panel_sync <= 2'h0;
    end
    else
    begin
      panel_meta <= i_panel_mode;
      panel_sync <= panel_meta;
    end
  end

  // ------------------------------------------------------------------
  // AHB-Lite register access
  // ------------------------------------------------------------------
  logic [15:0] setup_q [10];
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic        wr_pend;
  logic [3:0]  wr_slot;
  logic [3:0]  a_slot;
  logic        a_valid;
  logic [31:0] rd_word;
  logic        wr_setup;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_ctrl;
  logic        restart_cmd;

  assign a_valid     = i_hsel & i_htrans[1] & i_hready;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_comb
  begin
    case (i_haddr[31:2])
      `IDX_STARTUP_MODE_SELECT: a_slot = 4'h0;
      `IDX_HOLD_FLAG_RETENTION: a_slot = 4'h1;
      `IDX_BOARD_PORT2_SERVICE: a_slot = 4'h2;
      `IDX_BOARD_PORT1_SERVICE: a_slot = 4'h3;
      `IDX_PULSE_OUTPUT_SELECT: a_slot = 4'h4;
      `IDX_SERIAL_PORT_SHARE:   a_slot = 4'h5;
      `IDX_TOOL_PORT_SHARE:     a_slot = 4'h6;
      `IDX_CYCLE_OVERRUN_LIMIT: a_slot = 4'h7;
      `IDX_MINIMUM_CYCLE_TIME:  a_slot = 4'h8;
      `IDX_INPUT_FILTER_CONSTS: a_slot = 4'h9;
      `IDX_IRQ_STATUS:          a_slot = 4'ha;
      `IDX_IRQ_MASK:            a_slot = 4'hb;
      `IDX_CONTROL:             a_slot = 4'hc;
      `IDX_STATE:               a_slot = 4'hd;
      default:                  a_slot = 4'hf;
    endcase
  end

  logic [23:0] last_cycle;
  op_mode_t    op_mode;

  always_comb
  begin
    case (a_slot)
      4'ha:    rd_word = {29'h0, irq_status};
      4'hb:    rd_word = {29'h0, irq_mask};
      4'hc:    rd_word = {29'h0, op_mode, 1'b0};
      4'hd:    rd_word = {6'h0, o_forced_status_hold_flag, o_io_hold_flag, last_cycle};
      4'hf:    rd_word = 32'h0;
      default: rd_word = (a_slot < 4'ha) ? {16'h0, setup_q[a_slot]} : 32'h0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend  <= 1'b0;
      wr_slot  <= 4'hf;
      o_hrdata <= 32'h0;
    end
    else
    begin
      if (i_hready)
      begin
        wr_pend <= a_valid & i_hwrite;
        wr_slot <= a_slot;
      end
      if (a_valid && !i_hwrite)
        o_hrdata <= rd_word;
    end
  end

  assign wr_setup  = wr_pend & (wr_slot < 4'ha);
  assign wr_status = wr_pend & (wr_slot == 4'ha);
  assign wr_mask   = wr_pend & (wr_slot == 4'hb);
  assign wr_ctrl   = wr_pend & (wr_slot == 4'hc);

  // Stored as written; unused fields kept but never decoded
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 10; i++)
        setup_q[i] <= `SETUP_WORD_RST;
    end
    else if (wr_setup)
      setup_q[wr_slot] <= i_hwdata[15:0];
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask <= `IRQ_MASK_RST;
    else if (wr_mask)
      irq_mask <= i_hwdata[2:0];
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      restart_cmd <= 1'b0;
    else
      restart_cmd <= wr_ctrl & i_hwdata[`CTRL_RESTART_BIT];
  end

  // ------------------------------------------------------------------
  // Startup group: sampled only at boot or soft restart
  // ------------------------------------------------------------------
  logic        booted;
  logic        boot;
  logic [15:0] act_hold;
  logic [15:0] act_board1;
  logic [15:0] act_board2;

  assign boot = ~booted | restart_cmd;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      booted     <= 1'b0;
      act_hold   <= `SETUP_WORD_RST;
      act_board1 <= `SETUP_WORD_RST;
      act_board2 <= `SETUP_WORD_RST;
    end
    else
    begin
      booted <= 1'b1;
      if (boot)
      begin
        act_hold   <= setup_q[1];
        act_board1 <= setup_q[3];
        act_board2 <= setup_q[2];
      end
    end
  end

  assign o_io_hold_flag            = (act_hold[`IO_HOLD_FIELD] == 4'h1);
  assign o_forced_status_hold_flag = (act_hold[`FORCED_HOLD_FIELD] == 4'h1);
  assign o_board_port1_service     = act_board1;
  assign o_board_port2_service     = act_board2;

  // Resume keeps the present mode: it survives a soft restart only
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      op_mode <= MODE_PROGRAM;
    else if (boot)
    begin
      case (setup_q[0][`CODE_HI])
        `DESIG_PANEL:  op_mode <= (panel_sync == 2'b11) ? MODE_PROGRAM : op_mode_t'(panel_sync);
        `DESIG_RESUME: op_mode <= op_mode;
        `DESIG_STORED:
        begin
          case (setup_q[0][`CODE_LO])
            8'h01:   op_mode <= MODE_MONITOR;
            8'h02:   op_mode <= MODE_RUN;
            default: op_mode <= MODE_PROGRAM;
          endcase
        end
        default:       op_mode <= MODE_PROGRAM;
      endcase
    end
    else if (wr_ctrl && i_hwdata[`CTRL_MODE_WE_BIT] && i_hwdata[2:1] != 2'b11)
      op_mode <= op_mode_t'(i_hwdata[`CTRL_MODE_FIELD]);
  end

  assign o_op_mode = op_mode;

  // ------------------------------------------------------------------
  // Run-time group: latched at each operation start
  // ------------------------------------------------------------------
  logic        running;
  logic        running_d;
  logic        op_start;
  logic [15:0] act_pulse;
  logic [15:0] act_serial;
  logic [15:0] act_tool;
  logic [15:0] act_limit;
  logic [15:0] act_mincyc;
  logic [15:0] act_filter;

  assign running  = (op_mode != MODE_PROGRAM);
  assign op_start = running & ~running_d;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running_d  <= 1'b0;
      act_pulse  <= `SETUP_WORD_RST;
      act_serial <= `SETUP_WORD_RST;
      act_tool   <= `SETUP_WORD_RST;
      act_limit  <= `SETUP_WORD_RST;
      act_mincyc <= `SETUP_WORD_RST;
      act_filter <= `SETUP_WORD_RST;
    end
    else
    begin
      running_d <= running;
      if (op_start)
      begin
        act_pulse  <= setup_q[4];
        act_serial <= setup_q[5];
        act_tool   <= setup_q[6];
        act_limit  <= setup_q[7];
        act_mincyc <= setup_q[8];
        act_filter <= setup_q[9];
      end
    end
  end

  // One-hot by construction; BCD codes 16 to 99 drive nothing, but some non-BCD codes (such as D0) wrap in bcd2 onto a word
  logic [6:0] pulse_idx;
  assign pulse_idx = bcd2(act_pulse[`CODE_LO]);

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_pulse_word_onehot <= 16'h0000;
    else if (pulse_idx < 7'd16)
      o_pulse_word_onehot <= 16'h0001 << pulse_idx[3:0];
    else
      o_pulse_word_onehot <= 16'h0000;
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_filter_first_lo_ms    <= 8'(`FILTER_DEFAULT_MS);
      o_filter_first_hi_ms    <= 8'(`FILTER_DEFAULT_MS);
      o_filter_second_word_ms <= 8'(`FILTER_DEFAULT_MS);
    end
    else
    begin
      o_filter_first_lo_ms    <= filter_ms(act_filter[`FILT_FIRST_LO_FIELD]);
      o_filter_first_hi_ms    <= filter_ms(act_filter[`FILT_FIRST_HI_FIELD]);
      o_filter_second_word_ms <= filter_ms(act_filter[`FILT_SECOND_FIELD]);
    end
  end

  // ------------------------------------------------------------------
  // Cycle timing
  // ------------------------------------------------------------------
  logic [9:0]  tick_div;
  logic        tick;
  cyc_state_t  cyc_state;
  logic [23:0] elapsed;
  logic        overrun_seen;
  logic [16:0] limit_ms;
  logic [23:0] limit_ticks;
  logic [23:0] min_ticks;
  logic        cycle_end;
  logic        overrun_evt;

  assign tick = (tick_div == 10'(`TICK_CYCLES - 1));

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      tick_div <= 10'h000;
    else if (tick)
      tick_div <= 10'h000;
    else
      tick_div <= tick_div + 10'h001;
  end

  always_comb
  begin
    case (act_limit[`CODE_HI])
      `MON_UNIT_10MS:  limit_ms = 17'(bcd2(act_limit[`CODE_LO])) * 17'(`MON_UNIT_10MS_MS);
      `MON_UNIT_100MS: limit_ms = 17'(bcd2(act_limit[`CODE_LO])) * 17'(`MON_UNIT_100MS_MS);
      `MON_UNIT_1S:    limit_ms = 17'(bcd2(act_limit[`CODE_LO])) * 17'(`MON_UNIT_1S_MS);
      default:         limit_ms = 17'(`MON_FIXED_MS);
    endcase
  end

  assign limit_ticks = 24'(limit_ms) * 24'(`TICKS_PER_MS);
  assign min_ticks   = 24'(14'(bcd2(act_mincyc[15:8])) * 14'd100
                         + 14'(bcd2(act_mincyc[7:0])))
                       * 24'(`TICKS_PER_MS);
  assign cycle_end   = (cyc_state == CYC_PAD) && (elapsed >= min_ticks);
  assign overrun_evt = (cyc_state != CYC_IDLE) && !overrun_seen && (elapsed > limit_ticks);

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc_state     <= CYC_IDLE;
      elapsed       <= 24'h0;
      overrun_seen  <= 1'b0;
      last_cycle    <= 24'h0;
      o_cycle_start <= 1'b0;
    end
    else
    begin
      o_cycle_start <= 1'b0;
      if (tick && elapsed != 24'hffffff)
        elapsed <= elapsed + 24'h1;
      if (overrun_evt)
        overrun_seen <= 1'b1;
      case (cyc_state)
        CYC_IDLE:
        begin
          if (op_start)
          begin
            cyc_state     <= CYC_SCAN;
            elapsed       <= 24'h0;
            overrun_seen  <= 1'b0;
            o_cycle_start <= 1'b1;
          end
        end
        CYC_SCAN:
        begin
          if (!running)
            cyc_state <= CYC_IDLE;
          else if (i_scan_done)
            cyc_state <= CYC_PAD;
        end
        CYC_PAD:
        begin
          if (!running)
            cyc_state <= CYC_IDLE;
          else if (cycle_end)
          begin
            cyc_state     <= CYC_SCAN;
            last_cycle    <= elapsed;
            elapsed       <= 24'h0;
            overrun_seen  <= 1'b0;
            o_cycle_start <= 1'b1;
          end
        end
        default: cyc_state <= CYC_IDLE;
      endcase
    end
  end

  // Refreshed once per cycle from the previous cycle's length
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_serial_service_ticks <= 14'(`STOP_SERVICE_MS * `TICKS_PER_MS);
      o_tool_service_ticks   <= 14'(`STOP_SERVICE_MS * `TICKS_PER_MS);
    end
    else if (!running)
    begin
      o_serial_service_ticks <= 14'(`STOP_SERVICE_MS * `TICKS_PER_MS);
      o_tool_service_ticks   <= 14'(`STOP_SERVICE_MS * `TICKS_PER_MS);
    end
    else if (cycle_end)
    begin
      o_serial_service_ticks <= service_ticks(act_serial, elapsed);
      o_tool_service_ticks   <= service_ticks(act_tool, elapsed);
    end
  end

  // ------------------------------------------------------------------
  // Interrupt status, write one to clear; a new event wins
  // ------------------------------------------------------------------
  logic [2:0] irq_set;
  logic       restart_done;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      restart_done <= 1'b0;
    else
      restart_done <= boot;
  end

  assign irq_set = {restart_done, op_start, overrun_evt};

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_status <= 3'h0;
    else
      irq_status <= (irq_status & ~(wr_status ? i_hwdata[2:0] : 3'h0)) | irq_set;
  end

  assign o_irq = |(irq_status & irq_mask);

endmodule
`default_nettype wire

// *** src/setup_words_defines.svh ***
// Offsets, field positions, reset values and timing counts of the setup word bank
`ifndef SETUP_WORDS_DEFINES_SVH
`define SETUP_WORDS_DEFINES_SVH

// ------------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ------------------------------------------------------------------
`define IDX_STARTUP_MODE_SELECT   30'h000019c8
`define IDX_HOLD_FLAG_RETENTION   30'h000019c9
`define IDX_BOARD_PORT2_SERVICE   30'h000019d5
`define IDX_BOARD_PORT1_SERVICE   30'h000019d6
`define IDX_PULSE_OUTPUT_SELECT   30'h000019d7
`define IDX_SERIAL_PORT_SHARE     30'h000019d8
`define IDX_TOOL_PORT_SHARE       30'h000019d9
`define IDX_CYCLE_OVERRUN_LIMIT   30'h000019da
`define IDX_MINIMUM_CYCLE_TIME    30'h000019db
`define IDX_INPUT_FILTER_CONSTS   30'h000019dc
`define IDX_IRQ_STATUS            30'h00001a00
`define IDX_IRQ_MASK              30'h00001a01
`define IDX_CONTROL               30'h00001a02
`define IDX_STATE                 30'h00001a03

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define SETUP_WORD_RST            16'h0000
`define IRQ_MASK_RST              3'h0

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define CODE_LO                   7:0
`define CODE_HI                   15:8
`define IO_HOLD_FIELD             11:8
`define FORCED_HOLD_FIELD         15:12
`define FILT_FIRST_LO_FIELD       3:0
`define FILT_FIRST_HI_FIELD       7:4
`define FILT_SECOND_FIELD         11:8
`define CTRL_RESTART_BIT          0
`define CTRL_MODE_FIELD           2:1
`define CTRL_MODE_WE_BIT          4
`define IRQ_OVERRUN_BIT           0
`define IRQ_OP_START_BIT          1
`define IRQ_RESTART_BIT           2

// ------------------------------------------------------------------
// Codes
// ------------------------------------------------------------------
`define DESIG_PANEL               8'h00
`define DESIG_RESUME              8'h01
`define DESIG_STORED              8'h02
`define SHARE_FIXED               8'h00
`define SHARE_BCD                 8'h01
`define MON_FIXED                 8'h00
`define MON_UNIT_10MS             8'h01
`define MON_UNIT_100MS            8'h02
`define MON_UNIT_1S               8'h03

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CLK_PERIOD_NS             8
`define TICK_NS                   8000
`define TICK_CYCLES               (`TICK_NS / `CLK_PERIOD_NS)
`define NS_PER_MS                 1000000
`define TICKS_PER_MS              (`NS_PER_MS / `TICK_NS)
`define SHARE_DEFAULT_PCT         5
`define SERVICE_MIN_NS            256000
`define SERVICE_MAX_NS            65536000
`define SERVICE_MIN_TICKS         (`SERVICE_MIN_NS / `TICK_NS)
`define SERVICE_MAX_TICKS         (`SERVICE_MAX_NS / `TICK_NS)
`define STOP_SERVICE_MS           10
`define MON_FIXED_MS              120
`define MON_UNIT_10MS_MS          10
`define MON_UNIT_100MS_MS         100
`define MON_UNIT_1S_MS            1000
`define FILTER_DEFAULT_MS         8

`endif

// *** src/setup_words_pkg.sv ***
// Types shared by the setup word bank
package setup_words_pkg;

  typedef enum logic [1:0]
  {
    MODE_PROGRAM = 2'b00,
    MODE_MONITOR = 2'b01,
    MODE_RUN     = 2'b10
  } op_mode_t;

  typedef enum logic [1:0]
  {
    CYC_IDLE = 2'b00,
    CYC_SCAN = 2'b01,
    CYC_PAD  = 2'b10
  } cyc_state_t;

endpackage

// *** dv/controller_setup_words_checker.sv ***
// Port assertions for the setup word bank
`timescale 1ns/1ns
`default_nettype none
module controller_setup_words_checker
  import setup_words_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [1:0]  o_op_mode,
  input wire logic        o_cycle_start,
  input wire logic [15:0] o_pulse_word_onehot,
  input wire logic [13:0] o_serial_service_ticks,
  input wire logic [13:0] o_tool_service_ticks,
  input wire logic [7:0]  o_filter_first_lo_ms
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  // Three cycles give the share logic time to follow a stop
  sequence stopped;
    (o_op_mode == MODE_PROGRAM) [*3];
  endsequence
  sequence went_live;
    $past(o_op_mode) == MODE_PROGRAM && o_op_mode != MODE_PROGRAM;
  endsequence
  AST_BUS_OKAY:
    assert property (o_hreadyout && !o_hresp) else $error("bus stalled or errored");
  AST_ONE_PULSE_WORD:
    assert property ($onehot0(o_pulse_word_onehot)) else $error("pulse on two words");
  AST_SERIAL_RANGE:
    assert property (o_serial_service_ticks inside {[14'h0020:14'h2000]})
    else $error("serial service out of range");
  AST_TOOL_RANGE:
    assert property (o_tool_service_ticks inside {[14'h0020:14'h2000]})
    else $error("tool service out of range");
  AST_STOPPED_SERVICE:
    assert property (stopped |-> o_serial_service_ticks == 14'h04e2 &&
                     o_tool_service_ticks == 14'h04e2) else $error("stopped service not 10 ms");
  AST_FILTER_CODE:
    assert property ($onehot(o_filter_first_lo_ms)) else $error("filter time not decoded");
  AST_RUN_START:
    assert property (went_live |-> ##[0:2] o_cycle_start) else $error("no cycle start");
  AST_START_PULSE:
    assert property (o_cycle_start |=> !o_cycle_start) else $error("cycle start too long");
endmodule
bind controller_setup_words controller_setup_words_checker u_chk (.i_mclk(i_mclk),
  .i_arst_n(i_arst_n), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_op_mode(o_op_mode),
  .o_cycle_start(o_cycle_start), .o_pulse_word_onehot(o_pulse_word_onehot),
  .o_serial_service_ticks(o_serial_service_ticks),
  .o_tool_service_ticks(o_tool_service_ticks), .o_filter_first_lo_ms(o_filter_first_lo_ms));
`default_nettype wire

// *** dv/tb_controller_setup_words.sv ***
// Self-checking bench for the setup word bank
`timescale 1ns/1ns
`default_nettype none
`include "setup_words_defines.svh"
module tb_controller_setup_words;
  import setup_words_pkg::*;
  logic        i_mclk = 0, i_arst_n = 0, i_hsel = 0, i_hwrite = 0, i_scan_done = 0;
  logic [1:0]  i_htrans = 0, i_panel_mode = 0;
  logic [2:0]  i_hsize = 3'h2;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, d, q[$];
  wire logic   i_hready;
  logic        o_hreadyout, o_hresp, o_io_hold_flag, o_forced_status_hold_flag;
  logic        o_cycle_start, o_irq, rd_dphase = 0;
  logic [1:0]  o_op_mode;
  logic [15:0] o_pulse_word_onehot, o_board_port1_service, o_board_port2_service, oh = 16'h1;
  logic [13:0] o_serial_service_ticks, o_tool_service_ticks;
  logic [7:0]  o_filter_first_lo_ms, o_filter_first_hi_ms, o_filter_second_word_ms;
  logic [3:0]  c0, c1, c2;
  logic [15:0] su[6] = '{16'h0200, 16'h0201, 16'h0202, 16'h0100, 16'h0000, 16'h0000};
  logic [1:0]  pm[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
  logic [1:0]  em[6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h0};
  int          num_errors = 0, checked = 0, seed = 12, n, i, p;
  assign i_hready = o_hreadyout;
  always #4 i_mclk = ~i_mclk;
  // Scan engine stand-in: shortest legal scan
  always @(posedge i_mclk) i_scan_done <= o_cycle_start;
  controller_setup_words u_dut (.i_mclk, .i_arst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .i_panel_mode,
    .i_scan_done, .o_op_mode, .o_io_hold_flag, .o_forced_status_hold_flag, .o_cycle_start,
    .o_pulse_word_onehot, .o_serial_service_ticks, .o_tool_service_ticks,
    .o_filter_first_lo_ms, .o_filter_first_hi_ms, .o_filter_second_word_ms,
    .o_board_port1_service, .o_board_port2_service, .o_irq);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang_out;
    num_errors++;
    final_report();
  endtask
  task automatic rdy;
    @(posedge i_mclk);
    for (n = 0; o_hreadyout !== 1'b1; n++)
    begin
      if (n == 50)
        hang_out();
      @(posedge i_mclk);
    end
  endtask
  task automatic xfer(input logic [29:0] idx, input logic w, input logic [31:0] wd);
    @(posedge i_mclk);
    i_hsel <= 1'b1;
    i_haddr <= {idx, 2'b00};
    i_htrans <= 2'b10;
    i_hwrite <= w;
    rdy();
    i_htrans <= 2'b00;
    i_hwdata <= wd;
    rdy();
  endtask
  task automatic wr(input logic [29:0] idx, input logic [31:0] wd);
    xfer(idx, 1'b1, wd);
  endtask
  task automatic rd(input logic [29:0] idx, input logic [31:0] exp);
    q.push_back(exp);
    xfer(idx, 1'b0, $random(seed));
  endtask
  task automatic wait_hi(input int sel, input int lim = 100);
    for (n = 0; (sel ? o_cycle_start : o_irq) !== 1'b1; n++)
    begin
      if (n == lim)
        hang_out();
      @(negedge i_mclk);
    end
  endtask
  // Restart done is unmasked, so the interrupt paces each restart
  task automatic restart;
    wr(`IDX_CONTROL, 32'h1);
    wait_hi(0);
    wr(`IDX_IRQ_STATUS, 32'h4);
    repeat (3) @(negedge i_mclk);
  endtask
  function automatic logic [7:0] ms(input logic [3:0] c);
    return (c == 0 || c > 8) ? 8'h08 : 8'h01 << (c - 1);
  endfunction
  always @(posedge i_mclk)
  begin
    if (rd_dphase && o_hreadyout)
      chk("hrdata", q.pop_front(), o_hrdata);
    if (o_hreadyout)
      rd_dphase <= i_hsel && i_htrans[1] && !i_hwrite;
  end
  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (3) @(negedge i_mclk);
    chk("op_mode", MODE_PROGRAM, o_op_mode);
    chk("serial", 32'd1250, o_serial_service_ticks);
    chk("filter", 32'h8, o_filter_first_lo_ms);
    wr(30'(`IDX_STARTUP_MODE_SELECT + 2), $random(seed));
    for (i = 0; i < 21; i++)
      rd(30'(`IDX_STARTUP_MODE_SELECT + i), 32'h0);
    $display("reset values and unmapped words done");
    wr(`IDX_IRQ_MASK, 32'h4);
    repeat (2) @(negedge i_mclk);
    chk("irq", 32'h1, o_irq);
    wr(`IDX_IRQ_STATUS, 32'h4);
    repeat (2) @(negedge i_mclk);
    chk("irq", 32'h0, o_irq);
    for (i = 0; i < 2; i++)
    begin
      d = $random(seed);
      p = i ? 32'h0100 : 32'h1000;
      wr(`IDX_BOARD_PORT2_SERVICE, d);
      wr(`IDX_BOARD_PORT1_SERVICE, ~d);
      wr(`IDX_HOLD_FLAG_RETENTION, p);
      rd(`IDX_BOARD_PORT2_SERVICE, d[15:0]);
      chk("forced_hold", i, o_forced_status_hold_flag);
      restart();
      chk("port2", d[15:0], o_board_port2_service);
      chk("port1", 16'(~d), o_board_port1_service);
      chk("io_hold", p[8], o_io_hold_flag);
      chk("forced_hold", p[12], o_forced_status_hold_flag);
    end
    for (i = 0; i < 6; i++)
    begin
      @(posedge i_mclk);
      i_panel_mode <= pm[i];
      wr(`IDX_STARTUP_MODE_SELECT, su[i]);
      restart();
      chk("op_mode", em[i], o_op_mode);
    end
    $display("restart, hold flags and startup modes done");
    for (i = 0; i < 9; i++)
    begin
      p = 2 * i;
      c0 = 4'(i);
      c1 = 4'((i + 3) % 10);
      c2 = 4'(8 - i);
      wr(`IDX_PULSE_OUTPUT_SELECT, 32'(((p / 10) << 4) + p % 10));
      wr(`IDX_INPUT_FILTER_CONSTS, {20'h0, c2, c1, c0});
      wr(`IDX_SERIAL_PORT_SHARE, 32'(((i % 3) << 8) + 8'h50));
      chk("pulse_word", oh, o_pulse_word_onehot);
      wr(`IDX_CONTROL, 32'h14);
      wait_hi(1);
      repeat (8) @(negedge i_mclk);
      oh = p < 16 ? 16'h1 << p : 16'h0;
      chk("pulse_word", oh, o_pulse_word_onehot);
      chk("filter_lo", ms(c0), o_filter_first_lo_ms);
      chk("filter_hi", ms(c1), o_filter_first_hi_ms);
      chk("filter_2nd", ms(c2), o_filter_second_word_ms);
      chk("serial", 32'd32, o_serial_service_ticks);
      chk("tool", 32'd32, o_tool_service_ticks);
      wr(`IDX_CONTROL, 32'h10);
      repeat (4) @(negedge i_mclk);
      chk("serial", 32'd1250, o_serial_service_ticks);
    end
    // Ten-millisecond units times zero: first tick inside a cycle overruns
    wr(`IDX_CYCLE_OVERRUN_LIMIT, 32'h0100);
    wr(`IDX_IRQ_MASK, 32'h1);
    repeat (2) @(negedge i_mclk);
    chk("irq", 32'h0, o_irq);
    wr(`IDX_CONTROL, 32'h14);
    wait_hi(0, 5000);
    rd(`IDX_IRQ_STATUS, 32'h3);
    wr(`IDX_CONTROL, 32'h10);
    $display("run words, service shares and overrun done");
    final_report();
  end
endmodule
`default_nettype wire
